// [design/serial_host_pkg.sv]
package serial_host_pkg;

    // ----------------------------------------------------------------
    // protocol strap codes
    // ----------------------------------------------------------------
    localparam logic [1:0] PROTO_NONE = 2'h0;
    localparam logic [1:0] PROTO_SPI3 = 2'h1;
    localparam logic [1:0] PROTO_SPI4 = 2'h2;
    localparam logic [1:0] PROTO_I2C = 2'h3;
    localparam logic PARALLEL_PORT = 1'h0;

    // ----------------------------------------------------------------
    // framing
    // ----------------------------------------------------------------
    localparam int BYTE_WIDTH = 8;
    localparam logic [3:0] BITS_LAST = 4'h7;
    localparam logic [3:0] BITS_ACK = 4'h8;
    localparam int SPI_READ_BIT = 7;
    localparam logic [4:0] I2C_ADDR_BASE = 5'h0A;
    localparam logic [7:0] IDLE_TX_BYTE = 8'hFF;
    localparam logic [7:0] SPI_CMD_PAD = 8'h00;
    localparam int FIFO_DEPTH = 8;

    // ----------------------------------------------------------------
    // timing and reset values
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int HOST_SCL_PERIOD_NS = 1000;
    localparam int HALF_CYCLES = HOST_SCL_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);
    localparam logic [7:0] HALF_MID = 8'(HALF_CYCLES / 2 - 1);
    localparam logic [7:0] DEV_SYNC_RESET = 8'hFF;
    localparam logic [6:0] HOST_SYNC_RESET = 7'h7F;

    typedef enum {DS_IDLE, DS_CMD, DS_WR, DS_RD, DS_ACK, DS_RACK} dev_state_t;
    typedef enum {HS_IDLE, HS_START, HS_LOW, HS_HIGH, HS_STOP1, HS_STOP2} host_state_t;

endpackage : serial_host_pkg

// [design/serial_link_if.sv]
interface serial_link_if;
    logic scl;
    logic cs_n;
    logic sdi;
    logic sdi_host_o;
    logic sdi_host_oe;
    logic sdi_dev_o;
    logic sdi_dev_oe;
    logic sdo;
    logic sdo_dev_o;
    logic sdo_dev_oe;
    logic parallel_serial_strap;
    logic [1:0] serial_protocol_strap;
    logic [1:0] bus_address_select;

    // ----------------------------------------------------------------
    // wire resolution: undriven lines float high through pull-ups
    // ----------------------------------------------------------------
    assign sdi = ~((sdi_host_oe & ~sdi_host_o) | (sdi_dev_oe & ~sdi_dev_o));
    assign sdo = sdo_dev_oe ? sdo_dev_o : 1'b1;

    modport device (
        input scl, cs_n, sdi, parallel_serial_strap, serial_protocol_strap, bus_address_select,
        output sdi_dev_o, sdi_dev_oe, sdo_dev_o, sdo_dev_oe
    );
    modport host (
        input sdi, sdo, parallel_serial_strap, serial_protocol_strap, bus_address_select,
        output scl, cs_n, sdi_host_o, sdi_host_oe
    );
endinterface : serial_link_if

// [design/serial_host_device.sv]

module serial_host_device
    import serial_host_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    serial_link_if.device link,
    output logic [7:0] rx_data_out,
    output logic rx_valid_out,
    input wire logic rx_ready_in,
    input wire logic [7:0] tx_data_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out
);
    // ----------------------------------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------------------------------
    logic [7:0] sync_a;
    logic [7:0] sync_b;
    logic [7:0] prev;

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sync_a <= DEV_SYNC_RESET;
            sync_b <= DEV_SYNC_RESET;
            prev <= DEV_SYNC_RESET;
        end
        else
        begin
            sync_a <= {link.bus_address_select, link.serial_protocol_strap,
                       link.parallel_serial_strap, link.cs_n, link.sdi, link.scl};
            sync_b <= sync_a;
            prev <= sync_b;
        end
    end

    logic scl_b;
    logic sda_b;
    logic cs_b;
    logic [1:0] proto;
    logic [1:0] addr_sel;
    logic enabled;
    logic spi;
    logic spi3;
    logic spi4;
    logic i2c;
    logic rise;
    logic fall;
    logic i2c_start;
    logic i2c_stop;

    assign scl_b = sync_b[0];
    assign sda_b = sync_b[1];
    assign cs_b = sync_b[2];
    assign proto = sync_b[5:4];
    assign addr_sel = sync_b[7:6];
    assign enabled = (sync_b[3] != PARALLEL_PORT) && (proto != PROTO_NONE);
    assign spi3 = enabled && (proto == PROTO_SPI3);
    assign spi4 = enabled && (proto == PROTO_SPI4);
    assign i2c = enabled && (proto == PROTO_I2C);
    assign spi = spi3 || spi4;
    assign rise = scl_b && !prev[0];
    assign fall = !scl_b && prev[0];
    // start and stop only count while the clock is steadily high
    assign i2c_start = i2c && scl_b && prev[0] && !sda_b && prev[1];
    assign i2c_stop = i2c && scl_b && prev[0] && sda_b && !prev[1];

    // ----------------------------------------------------------------
    // frame state
    // ----------------------------------------------------------------
    dev_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic read_dir;
    logic drive;
    logic ack_ok;
    logic [7:0] next_byte;
    logic load;
    logic [7:0] load_byte;
    logic push;
    logic [7:0] push_data;
    logic push_ready;
    logic addr_match;

    assign next_byte = {shift_in[6:0], sda_b};
    assign addr_match = (shift_in[7:1] == {I2C_ADDR_BASE, addr_sel});
    assign load_byte = tx_valid_in ? tx_data_in : IDLE_TX_BYTE;
    // spi reloads on the fall after a byte, so its last bit stays up while the host samples it
    assign load = (spi && fall && state == DS_RD && bit_cnt == 4'h0)
                  || (i2c && fall
                   && ((state == DS_ACK && read_dir) || (state == DS_RACK && ack_ok)));
    assign tx_ready_out = load;
    assign push = (spi && rise && state == DS_WR && bit_cnt == BITS_LAST)
                  || (i2c && fall && state == DS_WR && bit_cnt == BITS_ACK);
    assign push_data = spi ? next_byte : shift_in;

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state <= DS_IDLE;
            bit_cnt <= 4'h0;
            shift_in <= 8'h00;
            shift_out <= 8'hFF;
            read_dir <= 1'b0;
            drive <= 1'b0;
            ack_ok <= 1'b0;
        end
        else if (!enabled || (spi && cs_b))
        begin
            state <= DS_IDLE;
            bit_cnt <= 4'h0;
            drive <= 1'b0;
        end
        else if (i2c_start)
        begin
            state <= DS_CMD;
            bit_cnt <= 4'h0;
            drive <= 1'b0;
        end
        else if (i2c_stop)
        begin
            state <= DS_IDLE;
            drive <= 1'b0;
        end
        else if (spi && state == DS_IDLE)
        begin
            state <= DS_CMD;
            bit_cnt <= 4'h0;
        end
        else if (rise)
        begin
            if (state == DS_CMD || state == DS_WR)
            begin
                shift_in <= next_byte;
            end
            if (state == DS_RACK)
            begin
                ack_ok <= !sda_b;
            end
            if (state == DS_CMD || state == DS_WR || state == DS_RD)
            begin
                bit_cnt <= bit_cnt + 4'h1;
            end
            if (spi && bit_cnt == BITS_LAST)
            begin
                bit_cnt <= 4'h0;
                if (state == DS_CMD)
                begin
                    read_dir <= next_byte[SPI_READ_BIT];
                    state <= next_byte[SPI_READ_BIT] ? DS_RD : DS_WR;
                end
            end
        end
        else if (fall)
        begin
            if (spi && state == DS_RD)
            begin
                drive <= 1'b1;
                if (load)
                begin
                    shift_out <= load_byte;
                end
                else
                begin
                    shift_out <= {shift_out[6:0], 1'b1};
                end
            end
            else if (i2c)
            begin
                case (state)
                    DS_CMD:
                    begin
                        if (bit_cnt == BITS_ACK)
                        begin
                            bit_cnt <= 4'h0;
                            read_dir <= shift_in[0];
                            drive <= addr_match;
                            state <= addr_match ? DS_ACK : DS_IDLE;
                        end
                    end
                    DS_WR:
                    begin
                        if (bit_cnt == BITS_ACK)
                        begin
                            // a full buffer refuses the byte with a not-acknowledge
                            bit_cnt <= 4'h0;
                            drive <= push_ready;
                            state <= push_ready ? DS_ACK : DS_IDLE;
                        end
                    end
                    DS_ACK:
                    begin
                        bit_cnt <= 4'h0;
                        drive <= read_dir;
                        state <= read_dir ? DS_RD : DS_WR;
                        if (load)
                        begin
                            shift_out <= load_byte;
                        end
                    end
                    DS_RD:
                    begin
                        if (bit_cnt == BITS_ACK)
                        begin
                            bit_cnt <= 4'h0;
                            drive <= 1'b0;
                            state <= DS_RACK;
                        end
                        else
                        begin
                            shift_out <= {shift_out[6:0], 1'b1};
                        end
                    end
                    DS_RACK:
                    begin
                        drive <= ack_ok;
                        state <= ack_ok ? DS_RD : DS_IDLE;
                        if (load)
                        begin
                            shift_out <= load_byte;
                        end
                    end
                    default:
                    begin
                        state <= DS_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // pin drivers: i2c is open drain, 3-wire spi drives both levels
    // ----------------------------------------------------------------
    assign link.sdi_dev_o = spi3 ? shift_out[7] : 1'b0;
    assign link.sdi_dev_oe = spi3 ? drive
                           : (i2c && (state == DS_ACK ? drive : drive && !shift_out[7]));
    assign link.sdo_dev_o = shift_out[7];
    assign link.sdo_dev_oe = spi4 && drive;

    // ----------------------------------------------------------------
    // received byte buffer
    // ----------------------------------------------------------------
    byte_fifo #(
        .WIDTH(BYTE_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) rx_fifo (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .in_data_in(push_data),
        .in_valid_in(push),
        .in_ready_out(push_ready),
        .out_data_out(rx_data_out),
        .out_valid_out(rx_valid_out),
        .out_ready_in(rx_ready_in)
    );
endmodule : serial_host_device

// [design/serial_host_master.sv]
module serial_host_master
    import serial_host_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    serial_link_if.host link,
    input wire logic xfer_valid_in,
    input wire logic xfer_read_in,
    input wire logic [7:0] xfer_data_in,
    output logic xfer_ready_out,
    output logic done_valid_out,
    output logic [7:0] done_data_out,
    output logic done_nack_out
);
    // ----------------------------------------------------------------
    // strap and data-line synchronisers
    // ----------------------------------------------------------------
    logic [6:0] sync_a;
    logic [6:0] sync_b;

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sync_a <= HOST_SYNC_RESET;
            sync_b <= HOST_SYNC_RESET;
        end
        else
        begin
            sync_a <= {link.bus_address_select, link.serial_protocol_strap,
                       link.parallel_serial_strap, link.sdo, link.sdi};
            sync_b <= sync_a;
        end
    end

    logic enabled;
    logic spi3;
    logic spi4;
    logic i2c;
    logic line_in;

    assign enabled = (sync_b[2] != PARALLEL_PORT) && (sync_b[4:3] != PROTO_NONE);
    assign spi3 = sync_b[4:3] == PROTO_SPI3;
    assign spi4 = sync_b[4:3] == PROTO_SPI4;
    assign i2c = sync_b[4:3] == PROTO_I2C;
    assign line_in = spi4 ? sync_b[1] : sync_b[0];

    // ----------------------------------------------------------------
    // bit sequencer; the clock is divided down here and driven out
    // ----------------------------------------------------------------
    host_state_t state;
    logic [7:0] half_cnt;
    logic [3:0] bit_idx;
    logic byte_idx;
    logic rd;
    logic [7:0] tx_sh;
    logic [7:0] wr_byte;
    logic [7:0] rx_sh;
    logic scl;
    logic cs_n;
    logic sda_o;
    logic sda_oe;
    logic tick;
    logic mid;
    logic sending;
    logic ack_bit;
    logic byte_end;

    assign tick = half_cnt == HALF_LAST;
    assign mid = half_cnt == HALF_MID;
    assign sending = !byte_idx || !rd;
    assign ack_bit = bit_idx == BITS_ACK;
    assign byte_end = i2c ? ack_bit : (bit_idx == BITS_LAST);
    assign xfer_ready_out = (state == HS_IDLE) && enabled;

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            half_cnt <= 8'h00;
        end
        else
        begin
            half_cnt <= (state == HS_IDLE || tick) ? 8'h00 : half_cnt + 8'h01;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state <= HS_IDLE;
            bit_idx <= 4'h0;
            byte_idx <= 1'b0;
            rd <= 1'b0;
            tx_sh <= 8'h00;
            wr_byte <= 8'h00;
            rx_sh <= 8'h00;
            scl <= 1'b1;
            cs_n <= 1'b1;
            sda_o <= 1'b1;
            sda_oe <= 1'b0;
            done_valid_out <= 1'b0;
            done_data_out <= 8'h00;
            done_nack_out <= 1'b0;
        end
        else
        begin
            done_valid_out <= 1'b0;
            case (state)
                HS_IDLE:
                begin
                    scl <= i2c;
                    if (xfer_valid_in && enabled)
                    begin
                        rd <= xfer_read_in;
                        wr_byte <= xfer_data_in;
                        bit_idx <= 4'h0;
                        byte_idx <= 1'b0;
                        done_nack_out <= 1'b0;
                        tx_sh <= i2c ? {I2C_ADDR_BASE, sync_b[6:5], xfer_read_in}
                                     : (SPI_CMD_PAD | {xfer_read_in, 7'h00});
                        cs_n <= i2c;
                        sda_o <= 1'b0;
                        sda_oe <= i2c;
                        state <= HS_START;
                    end
                end
                HS_START:
                begin
                    if (tick)
                    begin
                        scl <= 1'b0;
                        state <= HS_LOW;
                    end
                end
                HS_LOW:
                begin
                    if (mid)
                    begin
                        if (ack_bit || !sending)
                        begin
                            sda_oe <= 1'b0;
                        end
                        else
                        begin
                            sda_o <= i2c ? 1'b0 : tx_sh[7];
                            sda_oe <= i2c ? !tx_sh[7] : 1'b1;
                        end
                    end
                    if (tick)
                    begin
                        scl <= 1'b1;
                        state <= HS_HIGH;
                    end
                end
                HS_HIGH:
                begin
                    if (tick)
                    begin
                        scl <= 1'b0;
                        bit_idx <= bit_idx + 4'h1;
                        state <= HS_LOW;
                        if (!ack_bit)
                        begin
                            rx_sh <= {rx_sh[6:0], line_in};
                            tx_sh <= {tx_sh[6:0], 1'b0};
                        end
                        if (byte_end)
                        begin
                            bit_idx <= 4'h0;
                            byte_idx <= 1'b1;
                            tx_sh <= wr_byte;
                            if (!i2c && !byte_idx && rd)
                            begin
                                // free the shared line before the device turns it round
                                sda_oe <= spi3 ? 1'b0 : sda_oe;
                            end
                            if (byte_idx || (i2c && sending && line_in))
                            begin
                                done_nack_out <= i2c && sending && line_in;
                                sda_o <= 1'b0;
                                sda_oe <= i2c ? 1'b0 : sda_oe;
                                state <= HS_STOP1;
                            end
                        end
                    end
                end
                HS_STOP1:
                begin
                    if (mid)
                    begin
                        sda_oe <= i2c;
                    end
                    if (tick)
                    begin
                        scl <= i2c;
                        state <= i2c ? HS_STOP2 : HS_IDLE;
                        cs_n <= 1'b1;
                        done_valid_out <= !i2c;
                        done_data_out <= rx_sh;
                    end
                end
                HS_STOP2:
                begin
                    if (tick)
                    begin
                        sda_oe <= 1'b0;
                        done_valid_out <= 1'b1;
                        state <= HS_IDLE;
                    end
                end
                default:
                begin
                    state <= HS_IDLE;
                end
            endcase
        end
    end

    assign link.scl = scl;
    assign link.cs_n = cs_n;
    assign link.sdi_host_o = sda_o;
    assign link.sdi_host_oe = sda_oe;
endmodule : serial_host_master

module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic do_write;
    logic do_read;

    assign out_valid_out = (wr_ptr != rd_ptr);
    assign in_ready_out = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign do_write = in_valid_in && in_ready_out;
    assign do_read = out_valid_out && out_ready_in;
    assign out_data_out = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clock_in)
    begin
        if (do_write)
        begin
            mem[wr_ptr[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (do_write)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_read)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule : byte_fifo

// [tb/serial_link_sva.sv]
module serial_link_sva (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic scl,
    input wire logic cs_n,
    input wire logic sdi_dev_oe,
    input wire logic sdo_dev_oe,
    input wire logic parallel_serial_strap,
    input wire logic [1:0] serial_protocol_strap
);
    timeunit 1ns;
    timeprecision 1ps;
    logic off;
    logic [1:0] sp;
    assign sp = serial_protocol_strap;
    assign off = !parallel_serial_strap || sp == 2'h0;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    // ----------------------------------------------------------------
    // straps only change while idle; only the unselected and disabled checks allow six cycles of settling slack
    // ----------------------------------------------------------------
    a_sdo_four_wire: assert property (
        sdo_dev_oe |-> sp == 2'h2)
        else $error("data-out driven outside four-wire mode");
    a_sdi_shared_mode: assert property (
        sdi_dev_oe |-> sp == 2'h1 || sp == 2'h3)
        else $error("data line driven in a mode where it is input only");
    a_sdi_input_four: assert property (
        sdo_dev_oe |-> !sdi_dev_oe)
        else $error("data-in driven while four-wire read is active");
    a_select_spi_only: assert property (
        !cs_n |-> parallel_serial_strap && (sp == 2'h1 || sp == 2'h2))
        else $error("chip select asserted outside the spi modes");
    a_select_i2c_high: assert property (
        parallel_serial_strap && sp == 2'h3 |-> cs_n)
        else $error("chip select active in i2c mode");
    a_unselected_quiet: assert property (
        cs_n [*6] ##0 sp != 2'h3 |-> !sdi_dev_oe && !sdo_dev_oe)
        else $error("device drives data while not selected");
    a_frame_clocks: assert property (
        $fell(cs_n) |-> ##[1:40] $rose(scl))
        else $error("no bit clock after frame start");
    a_off_released: assert property (
        off [*6] |-> !sdi_dev_oe && !sdo_dev_oe)
        else $error("disabled port still drives a pin");
    a_off_clock_still: assert property (
        off [*6] |=> $stable(scl))
        else $error("bit clock moves while port disabled");
endmodule : serial_link_sva

// [tb/serial_host_interface_select_bench.sv]
module serial_host_interface_select_bench
    import serial_host_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic rx_ready_in = 1'b0;
    logic tx_valid_in = 1'b0;
    logic xfer_valid_in = 1'b0;
    logic xfer_read_in = 1'b0;
    logic [7:0] tx_data_in = 8'h00;
    logic [7:0] xfer_data_in = 8'h00;
    logic [7:0] rx_data_out, done_data_out;
    logic rx_valid_out, tx_ready_out, xfer_ready_out, done_valid_out, done_nack_out;
    logic [1:0] modes [3] = '{PROTO_SPI3, PROTO_SPI4, PROTO_I2C};
    int mismatches = 0;
    int checks = 0;
    serial_link_if link();
    serial_host_device serial_host_device_inst (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .link(link), .rx_data_out(rx_data_out), .rx_valid_out(rx_valid_out),
        .rx_ready_in(rx_ready_in), .tx_data_in(tx_data_in), .tx_valid_in(tx_valid_in),
        .tx_ready_out(tx_ready_out));
    serial_host_master serial_host_master_inst (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .link(link), .xfer_valid_in(xfer_valid_in), .xfer_read_in(xfer_read_in),
        .xfer_data_in(xfer_data_in), .xfer_ready_out(xfer_ready_out),
        .done_valid_out(done_valid_out), .done_data_out(done_data_out),
        .done_nack_out(done_nack_out));
    serial_link_sva serial_link_sva_inst (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .scl(link.scl), .cs_n(link.cs_n), .sdi_dev_oe(link.sdi_dev_oe),
        .sdo_dev_oe(link.sdo_dev_oe), .parallel_serial_strap(link.parallel_serial_strap),
        .serial_protocol_strap(link.serial_protocol_strap));
    always #25 clock_in = ~clock_in;
    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic complete_run();
        if (mismatches == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    task automatic set_mode(input logic ps, input logic [1:0] proto);
        // straps move only once the device has let go of the pins after a frame
        repeat (8) @(posedge clock_in);
        link.parallel_serial_strap <= ps;
        link.serial_protocol_strap <= proto;
        repeat (4) @(negedge clock_in);
    endtask : set_mode
    // bounded waits keep a hung handshake from stalling the run
    task automatic xfer(input logic rd, input logic [7:0] data);
        int n;
        for (n = 0; xfer_ready_out !== 1'b1 && n < 100; n++)
            @(negedge clock_in);
        @(posedge clock_in);
        xfer_valid_in <= 1'b1;
        xfer_read_in <= rd;
        xfer_data_in <= data;
        @(posedge clock_in);
        xfer_valid_in <= 1'b0;
        for (n = 0; done_valid_out !== 1'b1 && n < 2000; n++)
            @(negedge clock_in);
        check("done_valid", {7'h0, done_valid_out}, 8'h01);
    endtask : xfer
    task automatic pop(input logic [7:0] exp);
        int n;
        for (n = 0; rx_valid_out !== 1'b1 && n < 100; n++)
            @(negedge clock_in);
        check("rx_data", rx_data_out, exp);
        @(posedge clock_in);
        rx_ready_in <= 1'b1;
        @(posedge clock_in);
        rx_ready_in <= 1'b0;
        @(negedge clock_in);
    endtask : pop
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        link.parallel_serial_strap = 1'b1;
        link.serial_protocol_strap = PROTO_SPI4;
        link.bus_address_select = 2'h2;
        repeat (10) @(posedge clock_in);
        rst_n_in <= 1'b1;
        tx_valid_in <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            set_mode(1'b1, modes[i]);
            xfer(1'b0, 8'hA5 ^ 8'(i));
            check("write_nack", {7'h0, done_nack_out}, 8'h00);
            pop(8'hA5 ^ 8'(i));
            @(posedge clock_in);
            tx_data_in <= 8'h3C + 8'(i);
            xfer(1'b1, 8'h00);
            check("read_data", done_data_out, 8'h3C + 8'(i));
        end
        check("i2c_select", {7'h0, link.cs_n}, 8'h01);
        check("i2c_sdo", {7'h0, link.sdo}, 8'h01);
        // ninth byte has no room and is dropped; i2c then refuses with a nack
        set_mode(1'b1, PROTO_SPI4);
        for (int i = 0; i < 9; i++)
            xfer(1'b0, 8'h10 + 8'(i));
        set_mode(1'b1, PROTO_I2C);
        xfer(1'b0, 8'h99);
        check("full_nack", {7'h0, done_nack_out}, 8'h01);
        for (int i = 0; i < 8; i++)
            pop(8'h10 + 8'(i));
        check("drained", {7'h0, rx_valid_out}, 8'h00);
        set_mode(1'b1, PROTO_NONE);
        check("ready_none", {7'h0, xfer_ready_out}, 8'h00);
        set_mode(1'b0, PROTO_SPI3);
        check("ready_par", {7'h0, xfer_ready_out}, 8'h00);
        @(posedge clock_in);
        xfer_valid_in <= 1'b1;
        repeat (30) @(negedge clock_in);
        check("par_select", {7'h0, link.cs_n}, 8'h01);
        complete_run();
    end
    initial
    begin
        repeat (40000) @(posedge clock_in);
        mismatches++;
        complete_run();
    end
endmodule : serial_host_interface_select_bench
